// ---- core/cssu_top.sv ----
`timescale 1ns/1ps
// Contract
// - Fuse field picks the clock source.
// - Fuse bit one unprogrammed, zero programmed.
// - Selected source feeds the clock generator.
// - Deep-sleep wake waits oscillator start-up count.
// - Reset adds extra delay before running.
// - Reset delay counts watchdog oscillator cycles.
// - Reset delay is 0, 4096 or 65536 cycles.
// - Shipped: RC source, longest start-up, divide-by-eight.
// - Default prescales the RC clock by eight.
// - Core halts whenever core domain halted.
// - Peripherals on peripheral domain; some interrupts async.
// - Serial start detected while peripheral clock halted.
// - Program memory domain follows core domain.
// - Async timer domain runs through sleep.
// - Converter domain runs while core, peripherals halt.
// - Sleep mode halts unused domains.
// - Programmed divide fuse divides internal oscillator.
`include "cssu_map.svh"
module cssu_top
	import cssu_pkg::*;
#(
	parameter int WD_SHORT = `CSSU_WD_SHORT,
	parameter int WD_LONG = `CSSU_WD_LONG,
	parameter int OSC_XTAL = `CSSU_OSC_XTAL,
	parameter int OSC_LFXT = `CSSU_OSC_LFXT
) (
	// System
	input wire logic clk_sys,
	input wire logic rst,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Fuse pins
	input wire logic [3:0] sourceSelectFuses,
	input wire logic [1:0] startupLengthFuses,
	input wire logic divideByEightFuse,
	// Oscillator pins: crystal, low-frequency crystal, RC, external
	input wire logic [3:0] srcClkPins,
	input wire logic watchdogOscillatorPin,
	// Asynchronous event pins
	input wire logic extIrqPin,
	input wire logic serialStartPin,
	// Domain clock enables
	output logic coreClockDomain,
	output logic peripheralClockDomain,
	output logic programMemoryClockDomain,
	output logic asyncTimerClockDomain,
	output logic converterClockDomain,
	// Status
	output logic cpuRun,
	output logic extIrqDetect,
	output logic serialStartDetect
);
	localparam int NSYNC = 14;
	localparam int P_SRC = 7;
	localparam int P_WD = 11;
	localparam int P_IRQ = 12;
	localparam int P_START = 13;

	if (WD_SHORT < 1 || WD_LONG >= 131072 || OSC_XTAL >= 131072 || OSC_LFXT >= 131072)
	begin : g_bad
		$error("cssu_top counts must fit 17 bits");
	end

	logic [NSYNC-1:0] syncLevel;
	logic [NSYNC-1:0] syncRise;

	cssu_sync #(.W(NSYNC)) u_sync (
		.clk_sys(clk_sys),
		.rst(rst),
		.pinIn({serialStartPin, extIrqPin, watchdogOscillatorPin, srcClkPins,
			divideByEightFuse, startupLengthFuses, sourceSelectFuses}),
		.level(syncLevel),
		.rise(syncRise)
	);

	// Fuse capture, prescaler and state machine.
	cssu_state_t state_q, state_d;
	cssu_sleep_t sleepMode_q, sleepMode_d;
	logic [16:0] cnt_q, cnt_d;
	logic [3:0] sel_q, sel_d;
	logic [1:0] sut_q, sut_d;
	logic div8_q, div8_d;
	logic [2:0] preCnt_q, preCnt_d;
	logic irqDet_q, irqDet_d;
	logic startDet_q, startDet_d;
	logic [4:0] ctrl_q, ctrl_d;
	logic sleepReq;
	cssu_src_t srcRaw, srcEff;
	logic [1:0] srcIdx;
	logic srcTick, genTick, asyTick, div8Active;
	logic [16:0] wdTgt, oscTgt;
	logic coreOn, periphOn, adcOn;
	logic [4:0] domTick, domReq, domOut;

	function automatic logic [16:0] wdTarget(cssu_src_t s, logic c0, logic [1:0] startup_length_fuses);
		logic [2:0] k;
		k = {c0, startup_length_fuses};
		if (s == SRC_XTAL) begin
			case (k)
				3'h0, 3'h3, 3'h6: return 17'(WD_SHORT);
				3'h1, 3'h4, 3'h7: return 17'(WD_LONG);
				default: return 17'h0;
			endcase
		end
		case (startup_length_fuses)
			2'h0: return 17'h0;
			2'h1: return 17'(WD_SHORT);
			default: return 17'(WD_LONG);
		endcase
	endfunction : wdTarget

	function automatic logic [16:0] oscTarget(cssu_src_t s, logic c0, logic [1:0] startup_length_fuses);
		if (s == SRC_XTAL) begin
			if (c0) begin
				return (startup_length_fuses == 2'h0) ? `CSSU_OSC_1K : 17'(OSC_XTAL);
			end
			return startup_length_fuses[1] ? `CSSU_OSC_1K : `CSSU_OSC_258;
		end else if (s == SRC_LFXT) begin
			return c0 ? 17'(OSC_LFXT) : `CSSU_OSC_1K;
		end
		return `CSSU_OSC_RC;
	endfunction : oscTarget

	always_comb begin
		srcRaw = cssu_decode_src(sel_q);
		srcEff = (srcRaw == SRC_RSVD) ? SRC_RC : srcRaw;
		srcIdx = srcEff[1:0];
		srcTick = syncRise[P_SRC + int'(srcIdx)];
		div8Active = (srcEff == SRC_RC) && !div8_q && !ctrl_q[`CSSU_CTRL_DIVOFF_BIT];
		genTick = srcTick && (!div8Active || preCnt_q == 3'h7);
		asyTick = ctrl_q[`CSSU_CTRL_ASYEXT_BIT] ? syncRise[P_SRC + 3] : syncRise[P_SRC + 1];
		wdTgt = wdTarget(srcEff, sel_q[0], sut_q);
		oscTgt = oscTarget(srcEff, sel_q[0], sut_q);
		coreOn = (state_q == ST_RUN);
		periphOn = coreOn;
		adcOn = coreOn;
		if (state_q == ST_SLEEP) begin
			unique case (sleepMode_q)
				SLP_IDLE: begin
					periphOn = 1'b1;
					adcOn = 1'b1;
				end
				SLP_ADCNR: adcOn = 1'b1;
				SLP_PDOWN, SLP_PSAVE, SLP_STBY: adcOn = 1'b0;
				default: begin
					periphOn = 1'b1;
					adcOn = 1'b1;
				end
			endcase
		end
	end

	always_comb begin
		state_d = state_q;
		sleepMode_d = sleepMode_q;
		cnt_d = cnt_q;
		sel_d = sel_q;
		sut_d = sut_q;
		div8_d = div8_q;
		preCnt_d = srcTick ? preCnt_q + 3'h1 : preCnt_q;
		irqDet_d = syncRise[P_IRQ];
		startDet_d = syncRise[P_START] && !periphOn;
		unique case (state_q)
			ST_SAMPLE: begin
				cnt_d = cnt_q + 17'h1;
				if (cnt_q[2:0] == `CSSU_SETTLE) begin
					sel_d = syncLevel[3:0];
					sut_d = syncLevel[5:4];
					div8_d = syncLevel[6];
					cnt_d = 17'h0;
					preCnt_d = 3'h0;
					state_d = ST_RSTDLY;
				end
			end
			ST_RSTDLY: begin
				if (cnt_q >= wdTgt) begin
					cnt_d = 17'h0;
					state_d = ST_OSC;
				end else if (syncRise[P_WD]) begin
					cnt_d = cnt_q + 17'h1;
				end
			end
			ST_OSC, ST_WAKE: begin
				if (cnt_q >= oscTgt) begin
					cnt_d = 17'h0;
					state_d = ST_RUN;
				end else if (srcTick) begin
					cnt_d = cnt_q + 17'h1;
				end
			end
			ST_RUN: begin
				if (sleepReq) begin
					sleepMode_d = cssu_sleep_t'(ctrl_q[2:0]);
					state_d = ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				if (syncRise[P_IRQ] || syncRise[P_START]) begin
					cnt_d = 17'h0;
					state_d = (sleepMode_q == SLP_PDOWN || sleepMode_q == SLP_PSAVE)
						? ST_WAKE : ST_RUN;
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_q <= ST_SAMPLE;
			sleepMode_q <= SLP_IDLE;
			cnt_q <= 17'h0;
			sel_q <= `CSSU_DEF_SEL;
			sut_q <= `CSSU_DEF_SUT;
			div8_q <= `CSSU_DEF_DIV8;
			preCnt_q <= 3'h0;
			irqDet_q <= 1'b0;
			startDet_q <= 1'b0;
		end else begin
			state_q <= state_d;
			sleepMode_q <= sleepMode_d;
			cnt_q <= cnt_d;
			sel_q <= sel_d;
			sut_q <= sut_d;
			div8_q <= div8_d;
			preCnt_q <= preCnt_d;
			irqDet_q <= irqDet_d;
			startDet_q <= startDet_d;
		end
	end

	// Domain order: core, peripheral, program memory, async timer, converter.
	assign domTick = {genTick, asyTick, genTick, genTick, genTick};
	assign domReq = {adcOn, 1'b1, coreOn, periphOn, coreOn};

	for (genvar g = 0; g < 5; g++) begin : g_dom
		cssu_clock_gate u_gate (
			.clk_sys(clk_sys),
			.rst(rst),
			.srcTick(domTick[g]),
			.enReq(domReq[g]),
			.gatedTick(domOut[g])
		);
	end

	assign coreClockDomain = domOut[0];
	assign peripheralClockDomain = domOut[1];
	assign programMemoryClockDomain = domOut[2];
	assign asyncTimerClockDomain = domOut[3];
	assign converterClockDomain = domOut[4];
	assign cpuRun = state_q[3];
	assign extIrqDetect = irqDet_q;
	assign serialStartDetect = startDet_q;

	// AXI4-Lite slave: one write and one read at a time.
	logic awHeld_q, awHeld_d, wHeld_q, wHeld_d;
	logic [7:0] awAddr_q, awAddr_d;
	logic [31:0] wData_q, wData_d;
	logic wStrb0_q, wStrb0_d;
	logic bValid_q, bValid_d, rValid_q, rValid_d;
	logic [1:0] bResp_q, bResp_d, rResp_q, rResp_d;
	logic [31:0] rData_q, rData_d;

	function automatic logic mapped(logic [7:0] a);
		return a[7:4] == 4'h0 && a[1:0] == 2'h0;
	endfunction : mapped

	always_comb begin
		awHeld_d = awHeld_q;
		awAddr_d = awAddr_q;
		wHeld_d = wHeld_q;
		wData_d = wData_q;
		wStrb0_d = wStrb0_q;
		bValid_d = bValid_q && !s_axi_bready;
		bResp_d = bResp_q;
		rValid_d = rValid_q && !s_axi_rready;
		rData_d = rData_q;
		rResp_d = rResp_q;
		ctrl_d = ctrl_q;
		sleepReq = 1'b0;
		if (s_axi_awvalid && s_axi_awready) begin
			awHeld_d = 1'b1;
			awAddr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			wHeld_d = 1'b1;
			wData_d = s_axi_wdata;
			wStrb0_d = s_axi_wstrb[0];
		end
		if (awHeld_q && wHeld_q && !bValid_q) begin
			awHeld_d = 1'b0;
			wHeld_d = 1'b0;
			bValid_d = 1'b1;
			bResp_d = mapped(awAddr_q) ? `CSSU_RESP_OK : `CSSU_RESP_ERR;
			if (awAddr_q == `CSSU_CTRL_OFS && wStrb0_q) begin
				ctrl_d = wData_q[4:0];
			end
			if (awAddr_q == `CSSU_SLEEP_OFS) begin
				sleepReq = wStrb0_q && wData_q[0];
			end
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rValid_d = 1'b1;
			rResp_d = mapped(s_axi_araddr) ? `CSSU_RESP_OK : `CSSU_RESP_ERR;
			unique case (s_axi_araddr)
				`CSSU_CTRL_OFS: rData_d = {27'h0, ctrl_q};
				`CSSU_STATUS_OFS: rData_d = {21'h0, domReq, state_q};
				`CSSU_FUSE_OFS: rData_d = {24'h0, srcRaw == SRC_RSVD, div8_q, sut_q, sel_q};
				default: rData_d = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			awHeld_q <= 1'b0;
			awAddr_q <= 8'h00;
			wHeld_q <= 1'b0;
			wData_q <= 32'h0;
			wStrb0_q <= 1'b0;
			bValid_q <= 1'b0;
			bResp_q <= 2'h0;
			rValid_q <= 1'b0;
			rData_q <= 32'h0;
			rResp_q <= 2'h0;
			ctrl_q <= `CSSU_CTRL_RST;
		end else begin
			awHeld_q <= awHeld_d;
			awAddr_q <= awAddr_d;
			wHeld_q <= wHeld_d;
			wData_q <= wData_d;
			wStrb0_q <= wStrb0_d;
			bValid_q <= bValid_d;
			bResp_q <= bResp_d;
			rValid_q <= rValid_d;
			rData_q <= rData_d;
			rResp_q <= rResp_d;
			ctrl_q <= ctrl_d;
		end
	end

	assign s_axi_awready = !awHeld_q && !bValid_q;
	assign s_axi_wready = !wHeld_q && !bValid_q;
	assign s_axi_bvalid = bValid_q;
	assign s_axi_bresp = bResp_q;
	assign s_axi_arready = !rValid_q;
	assign s_axi_rvalid = rValid_q;
	assign s_axi_rdata = rData_q;
	assign s_axi_rresp = rResp_q;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	fuseHold_a: assert property (state_q != ST_SAMPLE |=> $stable(sel_q) && $stable(sut_q))
		else $error("fuse capture changed after sampling");
	coreHalt_a: assert property ((state_q != ST_RUN) [*4] |-> !coreClockDomain)
		else $error("core domain ticks outside run");
	flashCore_a: assert property (programMemoryClockDomain == coreClockDomain)
		else $error("program memory domain differs from core");
	resetCount_a: assert property (state_q == ST_RSTDLY && state_d == ST_OSC |-> cnt_q == wdTgt)
		else $error("reset delay left at wrong watchdog count");
	wakeCount_a: assert property (state_q == ST_WAKE ##1 state_q == ST_RUN |-> $past(cnt_q) >= oscTgt)
		else $error("wake before start-up count");
	divEight_a: assert property (genTick && div8Active |-> preCnt_q == 3'h7)
		else $error("prescale by eight broken");
	asyncRun_a: assert property (asyTick ##1 !$past(rst, 3) |-> asyncTimerClockDomain)
		else $error("async timer pulse lost");
	adcNoise_a: assert property (state_q == ST_SLEEP && sleepMode_q == SLP_ADCNR |-> adcOn && !periphOn)
		else $error("noise reduction domains wrong");
	startSeen_a: assert property (syncRise[P_START] && !periphOn |=> serialStartDetect)
		else $error("serial start lost while halted");
	bHold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
endmodule : cssu_top

// ---- core/cssu_map.svh ----
`ifndef CSSU_MAP_SVH
`define CSSU_MAP_SVH

// Register byte offsets on the AXI4-Lite port.
`define CSSU_CTRL_OFS 8'h00
`define CSSU_SLEEP_OFS 8'h04
`define CSSU_STATUS_OFS 8'h08
`define CSSU_FUSE_OFS 8'h0c

// Control register fields.
`define CSSU_CTRL_MODE_LSB 0
`define CSSU_CTRL_DIVOFF_BIT 3
`define CSSU_CTRL_ASYEXT_BIT 4
`define CSSU_CTRL_RST 5'h00

// AXI responses.
`define CSSU_RESP_OK 2'h0
`define CSSU_RESP_ERR 2'h2

// Shipped fuse values, used until the first capture after reset.
`define CSSU_DEF_SEL 4'h2
`define CSSU_DEF_SUT 2'h2
`define CSSU_DEF_DIV8 1'b0

// Timing counts.
`define CSSU_WD_SHORT 4096
`define CSSU_WD_LONG 65536
`define CSSU_OSC_XTAL 16384
`define CSSU_OSC_LFXT 32768
`define CSSU_OSC_1K 17'd1024
`define CSSU_OSC_258 17'd258
`define CSSU_OSC_RC 17'd6
`define CSSU_SETTLE 3'h3

`endif

// ---- core/cssu_pkg.sv ----
package cssu_pkg;

	typedef enum logic [5:0] {
		ST_SAMPLE = 6'h01,
		ST_RSTDLY = 6'h02,
		ST_OSC = 6'h04,
		ST_RUN = 6'h08,
		ST_SLEEP = 6'h10,
		ST_WAKE = 6'h20
	} cssu_state_t;

	typedef enum logic [2:0] {
		SRC_XTAL = 3'h0,
		SRC_LFXT = 3'h1,
		SRC_RC = 3'h2,
		SRC_EXT = 3'h3,
		SRC_RSVD = 3'h4
	} cssu_src_t;

	typedef enum logic [2:0] {
		SLP_IDLE = 3'h0,
		SLP_ADCNR = 3'h1,
		SLP_PDOWN = 3'h2,
		SLP_PSAVE = 3'h3,
		SLP_STBY = 3'h6
	} cssu_sleep_t;

	// A fuse bit at zero is programmed, so the codes below are raw pin levels.
	function automatic cssu_src_t cssu_decode_src(logic [3:0] sel);
		if (sel[3]) begin
			return SRC_XTAL;
		end else if (sel[2]) begin
			return SRC_LFXT;
		end else if (sel == 4'h2) begin
			return SRC_RC;
		end else if (sel == 4'h0) begin
			return SRC_EXT;
		end
		return SRC_RSVD;
	endfunction : cssu_decode_src

endpackage : cssu_pkg

// ---- core/cssu_sync.sv ----
`timescale 1ns/1ps
module cssu_sync #(
	parameter int W = 1
) (
	// System
	input wire logic clk_sys,
	input wire logic rst,
	// Pins
	input wire logic [W-1:0] pinIn,
	// Synchronised
	output logic [W-1:0] level,
	output logic [W-1:0] rise
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;
	logic [W-1:0] prev_q;

	if (W < 1) begin : g_bad
		$error("cssu_sync needs W of at least 1");
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			meta_q <= '0;
			sync_q <= '0;
			prev_q <= '0;
		end else begin
			meta_q <= pinIn;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	assign level = sync_q;
	assign rise = sync_q & ~prev_q;
endmodule : cssu_sync

// ---- core/cssu_clock_gate.sv ----
`timescale 1ns/1ps
module cssu_clock_gate (
	// System
	input wire logic clk_sys,
	input wire logic rst,
	// Control
	input wire logic srcTick,
	input wire logic enReq,
	// Gated enable
	output logic gatedTick
);
	logic en_q;
	logic en_d;
	logic gatedTick_q;
	logic gatedTick_d;

	// The gate only changes between pulses, so no pulse is ever cut short.
	always_comb begin
		en_d = srcTick ? en_q : enReq;
		gatedTick_d = srcTick & en_q;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			en_q <= 1'b0;
			gatedTick_q <= 1'b0;
		end else begin
			en_q <= en_d;
			gatedTick_q <= gatedTick_d;
		end
	end

	assign gatedTick = gatedTick_q;

	wholePulse_a: assert property (@(posedge clk_sys) disable iff (rst)
		gatedTick |-> $past(srcTick) && $past(en_q))
		else $error("gated pulse without a whole source pulse");
endmodule : cssu_clock_gate

// ---- testbench/cssu_osc_model.sv ----
`timescale 1ns/1ps
module cssu_osc_model (
	// System
	input wire logic clk_sys,
	// Oscillator outputs
	output logic [3:0] srcClkPins,
	output logic watchdogOscillatorPin
);
	// Source pin k toggles every 2+k cycles and the watchdog every 3, the same rate as source pin 1.
	int cnt[5] = '{default: 0};
	logic [4:0] lvl = 5'h00;

	always @(posedge clk_sys) begin
		for (int k = 0; k < 5; k++) begin
			if (cnt[k] >= (k < 4 ? k + 1 : 2)) begin
				cnt[k] <= 0;
				lvl[k] <= !lvl[k];
			end else begin
				cnt[k] <= cnt[k] + 1;
			end
		end
	end

	assign srcClkPins = lvl[3:0];
	assign watchdogOscillatorPin = lvl[4];
endmodule : cssu_osc_model

// ---- testbench/testbench.sv ----
`timescale 1ns/1ps
`include "cssu_map.svh"
module testbench;
	import cssu_pkg::*;
	typedef struct {logic [3:0] sel; logic [1:0] startup_length_fuses; logic div; int wd; int per;} cssu_case_t;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [7:0] awAddr = 8'h00, arAddr = 8'h00;
	logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
	logic [31:0] wData = 32'h0;
	logic [3:0] selFuse = 4'h2;
	logic [1:0] sutFuse = 2'h2;
	logic div8Fuse = 1'b0, irqPin = 1'b0, startPin = 1'b0, wdPrev = 1'b0;
	logic awReady, wReady, bValid, arReady, rValid, cpuRun, irqDet, startDet, wdPin;
	logic [1:0] bResp, rResp, r;
	logic [31:0] rData, d;
	logic [3:0] srcPins;
	logic [4:0] dom;
	int failures = 0, num_checks = 0;
	int cnt[9] = '{default: 0};
	int s[9];
	cssu_case_t tc[6];
	logic [2:0] mode[5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6};
	logic [4:0] req[5] = '{5'h1a, 5'h18, 5'h08, 5'h08, 5'h08};

	always #4 clk_sys = ~clk_sys;

	// Pulse counters: 0..4 domains, 5 interrupt detect, 6 start detect, 7 watchdog rises.
	// They update after the edge, so a snapshot taken at an edge never races them.
	always @(posedge clk_sys) begin
		for (int k = 0; k < 5; k++) begin
			cnt[k] <= cnt[k] + dom[k];
		end
		cnt[5] <= cnt[5] + irqDet;
		cnt[6] <= cnt[6] + startDet;
		cnt[7] <= cnt[7] + (wdPin && !wdPrev);
		wdPrev <= wdPin;
	end

	cssu_osc_model osc (.clk_sys(clk_sys), .srcClkPins(srcPins), .watchdogOscillatorPin(wdPin));

	cssu_top #(.WD_SHORT(8), .WD_LONG(16), .OSC_XTAL(32), .OSC_LFXT(32)) dut (
		.clk_sys(clk_sys), .rst(rst),
		.s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
		.s_axi_wdata(wData), .s_axi_wstrb(4'hf), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
		.s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
		.s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
		.s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
		.sourceSelectFuses(selFuse), .startupLengthFuses(sutFuse), .divideByEightFuse(div8Fuse),
		.srcClkPins(srcPins), .watchdogOscillatorPin(wdPin),
		.extIrqPin(irqPin), .serialStartPin(startPin),
		.coreClockDomain(dom[0]), .peripheralClockDomain(dom[1]),
		.programMemoryClockDomain(dom[2]), .asyncTimerClockDomain(dom[3]),
		.converterClockDomain(dom[4]), .cpuRun(cpuRun),
		.extIrqDetect(irqDet), .serialStartDetect(startDet)
	);

	task automatic tally_and_finish();
		$display("Checks %0d, mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : tally_and_finish

	task automatic time_out();
		failures++;
		$display("Error at %0t: wait ran out", $time);
		tally_and_finish();
	endtask : time_out

	task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check_word

	task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: response %h expected %h", $time, got, exp);
		end
	endtask : check_resp

	task automatic axi_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		int n;
		n = 0;
		@(posedge clk_sys);
		awAddr <= a;
		wData <= v;
		awValid <= 1'b1;
		wValid <= 1'b1;
		bReady <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (awValid && awReady) awValid <= 1'b0;
			if (wValid && wReady) wValid <= 1'b0;
			n++;
		end while (!bValid && n < 200);
		rs = bResp;
		bReady <= 1'b0;
		if (n >= 200) time_out();
	endtask : axi_write

	task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		int n;
		n = 0;
		@(posedge clk_sys);
		arAddr <= a;
		arValid <= 1'b1;
		rReady <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (arValid && arReady) arValid <= 1'b0;
			n++;
		end while (!rValid && n < 200);
		v = rData;
		rs = rResp;
		rReady <= 1'b0;
		if (n >= 200) time_out();
	endtask : axi_read

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		axi_read(a, d, r);
		check_resp(r, `CSSU_RESP_OK);
		check_word(d, exp);
	endtask : rd_chk

	task automatic wait_run();
		int n;
		n = 0;
		while (cpuRun !== 1'b1 && n < 10000) begin
			@(posedge clk_sys);
			n++;
		end
		if (n >= 10000) time_out();
	endtask : wait_run

	// Core pulses over a window must match the source rate; program memory tracks the core.
	task automatic measure(input int per);
		int c;
		s = cnt;
		repeat (640) @(posedge clk_sys);
		c = cnt[0] - s[0];
		check_word(32'(c >= 640 / per - 1 && c <= 640 / per + 1), 32'h1);
		check_word(32'((cnt[2] - s[2] - c) inside {-1, 0, 1}), 32'h1);
	endtask : measure

	initial begin
		tc = '{'{4'h2, 2'h2, 1'b0, 16, 64}, '{4'hf, 2'h1, 1'b1, 0, 4},
			'{4'h4, 2'h0, 1'b1, 0, 6}, '{4'h0, 2'h0, 1'b1, 0, 10},
			'{4'h3, 2'h0, 1'b1, 0, 8}, '{4'h2, 2'h1, 1'b1, 8, 8}};
		foreach (tc[i]) begin
			@(posedge clk_sys);
			selFuse <= tc[i].sel;
			sutFuse <= tc[i].startup_length_fuses;
			div8Fuse <= tc[i].div;
			rst <= 1'b1;
			repeat (5) @(posedge clk_sys);
			rst <= 1'b0;
			s = cnt;
			wait_run();
			check_word(32'(cnt[7] - s[7] >= tc[i].wd), 32'h1);
			check_word(32'(tc[i].wd == 0 || cnt[7] - s[7] < tc[i].wd + 12), 32'h1);
			selFuse <= ~tc[i].sel;
			sutFuse <= ~tc[i].startup_length_fuses;
			div8Fuse <= ~tc[i].div;
			rd_chk(`CSSU_FUSE_OFS, {24'h0, tc[i].sel inside {4'h1, 4'h3}, tc[i].div,
				tc[i].startup_length_fuses, tc[i].sel});
			rd_chk(`CSSU_CTRL_OFS, 32'h0);
			rd_chk(`CSSU_STATUS_OFS, {21'h0, 5'h1f, 6'(ST_RUN)});
			measure(tc[i].per);
			if (tc[i].div == 1'b0) begin
				axi_write(`CSSU_CTRL_OFS, 32'h8, r);
				measure(8);
			end
			$display("Start-up case %0d done", i);
		end
		axi_read(8'h10, d, r);
		check_resp(r, `CSSU_RESP_ERR);
		check_word(d, 32'h0);
		axi_write(8'h13, 32'h1, r);
		check_resp(r, `CSSU_RESP_ERR);
		for (int m = 0; m < 5; m++) begin
			axi_write(`CSSU_CTRL_OFS, {29'h0, mode[m]}, r);
			axi_write(`CSSU_SLEEP_OFS, 32'h1, r);
			repeat (10) @(posedge clk_sys);
			rd_chk(`CSSU_STATUS_OFS, {21'h0, req[m], 6'(ST_SLEEP)});
			check_word({31'h0, cpuRun}, 32'h0);
			s = cnt;
			repeat (100) @(posedge clk_sys);
			check_word(32'(cnt[0] - s[0]), 32'h0);
			check_word(32'(cnt[2] - s[2]), 32'h0);
			check_word(32'(cnt[3] > s[3]), 32'h1);
			check_word(32'(cnt[4] > s[4]), 32'(req[m][4]));
			check_word(32'(cnt[1] > s[1]), 32'(req[m][1]));
			if (m == 0) irqPin <= 1'b1;
			else startPin <= 1'b1;
			repeat (4) @(posedge clk_sys);
			irqPin <= 1'b0;
			startPin <= 1'b0;
			wait_run();
			// The detect pulse lands with the wake, so let the counters take it first.
			repeat (2) @(posedge clk_sys);
			check_word(32'(cnt[5] - s[5]), 32'(m == 0));
			check_word(32'(cnt[6] - s[6]), 32'(m != 0));
			$display("Sleep mode %0d done", mode[m]);
		end
		tally_and_finish();
	end
endmodule : testbench
